// >>> forced_conversion_control.sv
// Power mode, forced conversion and magnetic reset sequencing of a magnetometer
`timescale 1ns/1ps
`include "forced_conv_consts.svh"

module forced_conversion_control #(
   parameter int unsigned FAST_SAMPLE_CYC = `FAST_SAMPLE_NS / `CLK_PERIOD_NS - 1,
   parameter int unsigned NORM_SAMPLE_CYC = `NORM_SAMPLE_NS / `CLK_PERIOD_NS,
   parameter int unsigned CAP_CHARGE_CYC = `CAP_CHARGE_NS / `CLK_PERIOD_NS - 1,
   parameter int unsigned STIME_TICK_CYC = `STIME_TICK_NS / `CLK_PERIOD_NS
) (
   input wire logic clk, // 200 MHz clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state when low
   input wire logic cmd_wr, // Power command write strobe
   input wire logic [7:0] cmd_code, // Power command code
   input wire logic [1:0] avg_sel, // Averaging field of rate_and_averaging_reg
   input wire logic [2:0] axis_en, // Enabled axes, bit 0 is X
   input wire logic selftest_x_req, // Self-test request on X
   input wire logic selftest_y_req, // Self-test request on Y
   input wire logic odr_tick, // Output-rate tick in normal mode
   input wire logic cap_charged_pin, // Reset capacitor charged, from pin
   input wire logic [23:0] adc_x, // X channel result
   input wire logic [23:0] adc_y, // Y channel result
   input wire logic [23:0] adc_z, // Z channel result
   input wire logic [23:0] adc_t, // Temperature channel result
   input wire logic rd_en, // Data register read strobe
   input wire logic [7:0] rd_addr, // Data register address
   input wire logic burst_active, // Host burst read in progress
   input wire logic drdy_clr, // Clear data-ready status
   output logic [7:0] rd_data, // Read byte, one cycle after rd_en
   output logic drdy, // Data-ready status
   output logic suspend_state, // In suspend and idle
   output logic normal_state, // In normal mode and idle
   output logic conv_busy, // Charging, resetting, converting or storing
   output logic cap_charge_en, // Charge the reset capacitor
   output logic mrst_pulse, // Magnetic reset drive
   output logic [2:0] axis_conv_en, // Axes being converted
   output logic temp_conv_en, // Temperature being converted
   output logic st_field_x, // Self-test field on X
   output logic st_field_y // Self-test field on Y
);
   // ----------------------------------------------------------------
   // Cycle counts
   // ----------------------------------------------------------------
   // Counts come from the exact clock, well inside oscillator drift
   localparam logic [23:0] FAST_C = 24'(FAST_SAMPLE_CYC);
   localparam logic [23:0] NORM_C = 24'(NORM_SAMPLE_CYC);
   localparam logic [23:0] CAP_C = 24'(CAP_CHARGE_CYC);
   localparam logic [15:0] TICK_C = 16'(STIME_TICK_CYC);
   localparam logic [23:0] MRST_C =
      24'((`MRST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);

   forced_conv_pkg::ctrl_state_t q;
   forced_conv_pkg::ctrl_state_t d;
   logic in_range;
   logic [3:0] rd_idx;
   logic [23:0] conv_load;
   logic is_forced;

   assign in_range = (rd_addr >= `DATA_FIRST) && (rd_addr <= `DATA_LAST);
   assign rd_idx = in_range ? 4'(rd_addr - `DATA_FIRST) : `NO_INDEX;
   assign is_forced = (cmd_code == `FORCED_NORMAL_CMD) || (cmd_code == `FORCED_FAST_CMD);
   // Sample time times 1, 2, 4 or 8
   assign conv_load = ((q.fast ? FAST_C : NORM_C) << q.avg) - 24'h000001;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.cap_s1 = cap_charged_pin;
      d.cap_s2 = q.cap_s1;
      d.mem_wr = 1'b0;
      d.in_burst = burst_active;
      if (!burst_active) begin
         d.freeze = 1'b0;
      end else if (rd_en && !q.in_burst && in_range) begin
         d.freeze = 1'b1;
      end
      if (drdy_clr) begin
         d.drdy = 1'b0;
      end
      // Sensortime runs only while in normal operation
      if (q.state == forced_conv_pkg::ST_NORMAL || q.ret_normal) begin
         if (q.tick >= TICK_C - 16'h0001) begin
            d.tick = 16'h0000;
            d.stime = q.stime + 24'h000001;
         end else begin
            d.tick = q.tick + 16'h0001;
         end
      end
      if (q.timer != 24'h000000) begin
         d.timer = q.timer - 24'h000001;
      end
      // A suspend command during a normal-mode cycle ends it in suspend, unless it comes in the cycle that stores the results
      if (cmd_wr && cmd_code == `CMD_SUSPEND && q.ret_normal) begin
         d.ret_normal = 1'b0;
      end
      case (q.state)
         forced_conv_pkg::ST_SUSPEND: begin
            if (cmd_wr && is_forced) begin
               d.state = forced_conv_pkg::ST_CHARGE;
               d.timer = CAP_C;
               d.do_conv = 1'b1;
               d.ret_normal = 1'b0;
               d.fast = (cmd_code == `FORCED_FAST_CMD);
               d.avg = avg_sel;
               d.axes = axis_en;
               d.st_x = selftest_x_req && !selftest_y_req;
               d.st_y = selftest_y_req && !selftest_x_req;
            end else if (cmd_wr && cmd_code == `CMD_MAG_RESET) begin
               d.state = forced_conv_pkg::ST_CHARGE;
               d.timer = CAP_C;
               d.do_conv = 1'b0;
               d.ret_normal = 1'b0;
            end else if (cmd_wr && cmd_code == `CMD_NORMAL) begin
               d.state = forced_conv_pkg::ST_NORMAL;
            end
            // Other codes leave suspend untouched
         end
         forced_conv_pkg::ST_NORMAL: begin
            // Forced codes fall through here unheeded
            if (cmd_wr && cmd_code == `CMD_SUSPEND) begin
               d.state = forced_conv_pkg::ST_SUSPEND;
            end else if (odr_tick) begin
               d.state = forced_conv_pkg::ST_CHARGE;
               d.timer = CAP_C;
               d.do_conv = 1'b1;
               d.ret_normal = 1'b1;
               d.fast = 1'b0;
               d.avg = avg_sel;
               d.axes = axis_en;
               d.st_x = 1'b0;
               d.st_y = 1'b0;
            end
         end
         forced_conv_pkg::ST_CHARGE: begin
            // Pin or timeout, whichever first
            if (q.cap_s2 || q.timer == 24'h000000) begin
               d.state = forced_conv_pkg::ST_MRST;
               d.timer = MRST_C - 24'h000001;
            end
         end
         forced_conv_pkg::ST_MRST: begin
            if (q.timer == 24'h000000) begin
               if (q.do_conv) begin
                  d.state = forced_conv_pkg::ST_CONV;
                  d.timer = conv_load;
               end else begin
                  d.state = forced_conv_pkg::ST_SUSPEND;
               end
            end
         end
         forced_conv_pkg::ST_CONV: begin
            // Requests arriving here are dropped, except a suspend during a normal-mode cycle
            if (q.timer == 24'h000000) begin
               d.state = forced_conv_pkg::ST_STORE;
               d.result = {q.stime, adc_t, adc_z, adc_y, adc_x};
            end
         end
         forced_conv_pkg::ST_STORE: begin
            // Results wait for a frozen burst to end, one starting now too
            if (!d.freeze) begin
               d.mem_wr = 1'b1;
               d.drdy = 1'b1;
               d.state = q.ret_normal ? forced_conv_pkg::ST_NORMAL
                                      : forced_conv_pkg::ST_SUSPEND;
            end
         end
         default: begin
            d.state = forced_conv_pkg::ST_SUSPEND;
         end
      endcase
      d.suspend_o = (d.state == forced_conv_pkg::ST_SUSPEND);
      d.normal_o = (d.state == forced_conv_pkg::ST_NORMAL);
      d.busy_o = !d.suspend_o && !d.normal_o;
      d.charge_o = (d.state == forced_conv_pkg::ST_CHARGE);
      d.mrst_o = (d.state == forced_conv_pkg::ST_MRST);
      d.axes_o = (d.state == forced_conv_pkg::ST_CONV) ? d.axes : 3'h0;
      d.temp_o = (d.state == forced_conv_pkg::ST_CONV);
      d.st_x_o = (d.state == forced_conv_pkg::ST_CONV) && d.st_x;
      d.st_y_o = (d.state == forced_conv_pkg::ST_CONV) && d.st_y;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
         q.state <= forced_conv_pkg::ST_CHARGE; // Boot reset first
         q.timer <= CAP_C;
         q.busy_o <= 1'b1;
         q.charge_o <= 1'b1;
      end else if (ce) begin
         q <= d;
      end
   end

   result_mem u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .wr_en(q.mem_wr),
      .wr_mask({2'b11, q.axes}), // Temperature and time always
      .wr_data(q.result),
      .rd_idx(rd_idx),
      .rd_data(rd_data)
   );

   assign drdy = q.drdy;
   assign suspend_state = q.suspend_o;
   assign normal_state = q.normal_o;
   assign conv_busy = q.busy_o;
   assign cap_charge_en = q.charge_o;
   assign mrst_pulse = q.mrst_o;
   assign axis_conv_en = q.axes_o;
   assign temp_conv_en = q.temp_o;
   assign st_field_x = q.st_x_o;
   assign st_field_y = q.st_y_o;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   logic boot_mrst_seen_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         boot_mrst_seen_q <= 1'b0;
      end else if (q.mrst_o) begin
         boot_mrst_seen_q <= 1'b1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n || !ce);

   sequence forced_req_s;
      cmd_wr && is_forced && q.state == forced_conv_pkg::ST_SUSPEND;
   endsequence
   sequence conv_entry_s;
      q.state == forced_conv_pkg::ST_CONV && $past(q.state) != forced_conv_pkg::ST_CONV;
   endsequence

   forced_start_a: assert property (forced_req_s |=> q.state == forced_conv_pkg::ST_CHARGE && q.do_conv)
      else $error("forced request in suspend not started");
   forced_return_a: assert property (q.state == forced_conv_pkg::ST_STORE && !d.freeze && !q.ret_normal
      |=> q.suspend_o ##0 drdy)
      else $error("forced conversion did not return to suspend");
   conv_bound_a: assert property (q.state == forced_conv_pkg::ST_CONV |-> q.timer < (NORM_C << 3))
      else $error("conversion time over bound");
   temp_conv_a: assert property (q.state == forced_conv_pkg::ST_CONV |-> temp_conv_en)
      else $error("temperature not converted");
   busy_ignore_a: assert property (cmd_wr && is_forced && q.state == forced_conv_pkg::ST_CONV
      && q.timer != 24'h000000 |=> q.state == forced_conv_pkg::ST_CONV && $stable(q.fast))
      else $error("forced request disturbed running conversion");
   normal_ignore_a: assert property (cmd_wr && is_forced && !odr_tick && q.state == forced_conv_pkg::ST_NORMAL
      |=> q.state == forced_conv_pkg::ST_NORMAL)
      else $error("forced request accepted in normal mode");
   boot_reset_a: assert property (q.suspend_o |-> boot_mrst_seen_q)
      else $error("suspend reached without boot magnetic reset");
   mrst_before_a: assert property (conv_entry_s |-> $past(q.state) == forced_conv_pkg::ST_MRST)
      else $error("conversion without preceding magnetic reset");
   charge_bound_a: assert property (q.state == forced_conv_pkg::ST_CHARGE |-> q.timer <= CAP_C)
      else $error("capacitor charge over bound");
   selftest_one_a: assert property (!(st_field_x && st_field_y))
      else $error("self-test on two axes");
   freeze_hold_a: assert property (q.freeze |-> !q.mem_wr)
      else $error("data written during burst");
   unknown_cmd_a: assert property (cmd_wr && q.state == forced_conv_pkg::ST_SUSPEND && !is_forced
      && cmd_code != `CMD_NORMAL && cmd_code != `CMD_MAG_RESET |=> q.suspend_o)
      else $error("unknown command changed state");

endmodule : forced_conversion_control

// >>> forced_conv_consts.svh
// Named constants for the forced conversion controller
`ifndef FORCED_CONV_CONSTS_SVH
`define FORCED_CONV_CONSTS_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define FAST_SAMPLE_NS 5000000
`define NORM_SAMPLE_NS 3750000
`define CAP_CHARGE_NS 8000000
`define MRST_PULSE_NS 1000
`define STIME_TICK_NS 40000

// ----------------------------------------------------------------
// Power command codes
// ----------------------------------------------------------------
`define CMD_SUSPEND 8'h00
`define CMD_NORMAL 8'h01
`define CMD_UPDATE 8'h02
`define FORCED_NORMAL_CMD 8'h03
`define FORCED_FAST_CMD 8'h04
`define CMD_MAG_RESET 8'h05

// ----------------------------------------------------------------
// Result register map
// ----------------------------------------------------------------
`define DATA_FIRST 8'h31
`define DATA_LAST 8'h3F
`define DATA_BYTES 15
`define NO_INDEX 4'hF
`define FIELD_W 24
`define NUM_FIELDS 5
`define FLD_X 0
`define FLD_Y 1
`define FLD_Z 2
`define FLD_T 3
`define FLD_TIME 4

`endif

// >>> forced_conv_pkg.sv
// Types shared by the forced conversion controller and its result memory
package forced_conv_pkg;

   typedef enum logic [2:0] {ST_CHARGE, ST_MRST, ST_CONV, ST_STORE, ST_SUSPEND, ST_NORMAL} pwr_state_t;

   typedef struct packed {
      pwr_state_t state;
      logic [23:0] timer;
      logic do_conv;
      logic ret_normal;
      logic fast;
      logic [1:0] avg;
      logic [2:0] axes;
      logic st_x;
      logic st_y;
      logic cap_s1;
      logic cap_s2;
      logic in_burst;
      logic freeze;
      logic [15:0] tick;
      logic [23:0] stime;
      logic [119:0] result;
      logic mem_wr;
      logic drdy;
      logic suspend_o;
      logic normal_o;
      logic busy_o;
      logic charge_o;
      logic mrst_o;
      logic [2:0] axes_o;
      logic temp_o;
      logic st_x_o;
      logic st_y_o;
   } ctrl_state_t;

   typedef struct packed {
      logic [14:0][7:0] bytes;
      logic [7:0] rd;
   } mem_state_t;

endpackage : forced_conv_pkg

// >>> result_mem.sv
// Result byte store for magnetic, temperature and sensortime data
`timescale 1ns/1ps
`include "forced_conv_consts.svh"

module result_mem (
   input wire logic clk, // System clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic wr_en, // Write the masked fields
   input wire logic [4:0] wr_mask, // One bit per 24-bit field
   input wire logic [119:0] wr_data, // Fields, field 0 lowest
   input wire logic [3:0] rd_idx, // Byte index, NO_INDEX reads zero
   output logic [7:0] rd_data // Registered read byte
);
   forced_conv_pkg::mem_state_t q;
   forced_conv_pkg::mem_state_t d;

   always_comb begin
      d = q;
      if (wr_en) begin
         for (int f = 0; f < `NUM_FIELDS; f++) begin
            if (wr_mask[f]) begin
               for (int b = 0; b < 3; b++) begin
                  d.bytes[f * 3 + b] = wr_data[f * `FIELD_W + b * 8 +: 8];
               end
            end
         end
      end
      d.rd = (rd_idx < 4'(`DATA_BYTES)) ? q.bytes[rd_idx] : 8'h00;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign rd_data = q.rd;

endmodule : result_mem

// >>> analog_front_model.sv
// Behavioural model of the reset capacitor and the channel converters
`timescale 1ns/1ps

module analog_front_model #(
   parameter int unsigned CHARGE_CYC = 8, // Charging time in cycles
   parameter logic [23:0] ST_FIELD = 24'h000514 // Self-test field in counts
) (
   input wire logic clk, // System clock
   input wire logic slow_charge, // Capacitor never charges while high
   input wire logic cap_charge_en, // Charging requested
   input wire logic mrst_pulse, // Reset pulse drains the capacitor
   input wire logic conv_on, // Conversion running
   input wire logic st_field_x, // Self-test field on X
   input wire logic st_field_y, // Self-test field on Y
   input wire logic [95:0] amb, // Ambient T, Z, Y, X
   output logic cap_charged_pin, // Capacitor charged
   output logic [23:0] adc_x, // X result
   output logic [23:0] adc_y, // Y result
   output logic [23:0] adc_z, // Z result
   output logic [23:0] adc_t // Temperature result
);
   logic [23:0] vx;
   logic [23:0] vy;
   int unsigned chg_cnt = 0;

   initial cap_charged_pin = 1'b0;

   // Charge only builds while requested; a reset pulse drains it
   always @(posedge clk) begin
      if (mrst_pulse) begin
         chg_cnt <= 0;
         cap_charged_pin <= 1'b0;
      end else if (cap_charge_en && !slow_charge) begin
         chg_cnt <= chg_cnt + 1;
         cap_charged_pin <= (chg_cnt + 1 >= CHARGE_CYC);
      end
   end

   assign vx = amb[23:0] + (st_field_x ? ST_FIELD : 24'h000000);
   assign vy = amb[47:24] + (st_field_y ? ST_FIELD : 24'h000000);
   // Outside a conversion nothing valid is held, so show the inverse
   assign {adc_t, adc_z, adc_y, adc_x} = conv_on ? {amb[95:48], vy, vx} : ~{amb[95:48], vy, vx};
endmodule : analog_front_model

// >>> forced_conversion_control_tb.sv
// Self-checking bench for the forced conversion controller
`timescale 1ns/1ps
`include "forced_conv_consts.svh"

`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %0t %s", $time, m); end end

module forced_conversion_control_tb;
   localparam int FAST = 50;
   localparam int NORM = 60;
   localparam int CAPC = 40;
   localparam logic [23:0] ST = 24'h000514;
   logic clk, rst_n, cmd_wr, selftest_x_req, selftest_y_req, odr_tick, cap_charged_pin;
   logic rd_en, burst_active, drdy_clr, slow, drdy, suspend_state, normal_state, conv_busy;
   logic cap_charge_en, mrst_pulse, temp_conv_en, st_field_x, st_field_y;
   logic [7:0] cmd_code, rd_addr, rd_data, d, old;
   logic [1:0] avg_sel, st_seen;
   logic [2:0] axis_en, axis_conv_en, conv_axes;
   logic [23:0] adc_x, adc_y, adc_z, adc_t, ax, ay, az, at;
   logic [7:0] bad [3] = '{8'h7E, `CMD_UPDATE, 8'hFF};
   logic [1:0] st_req [3] = '{2'h1, 2'h3, 2'h2};
   logic [1:0] st_exp [3] = '{2'h1, 2'h0, 2'h2};
   int n_mismatch = 0, cmp_count = 0, n_mrst, n_chg, n_conv;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   forced_conversion_control #(.FAST_SAMPLE_CYC(FAST), .NORM_SAMPLE_CYC(NORM),
      .CAP_CHARGE_CYC(CAPC), .STIME_TICK_CYC(10)) dut (.clk(clk), .rst_n(rst_n), .ce(1'b1),
      .cmd_wr(cmd_wr), .cmd_code(cmd_code), .avg_sel(avg_sel), .axis_en(axis_en),
      .selftest_x_req(selftest_x_req), .selftest_y_req(selftest_y_req), .odr_tick(odr_tick),
      .cap_charged_pin(cap_charged_pin), .adc_x(adc_x), .adc_y(adc_y), .adc_z(adc_z),
      .adc_t(adc_t), .rd_en(rd_en), .rd_addr(rd_addr), .burst_active(burst_active),
      .drdy_clr(drdy_clr), .rd_data(rd_data), .drdy(drdy), .suspend_state(suspend_state),
      .normal_state(normal_state), .conv_busy(conv_busy), .cap_charge_en(cap_charge_en),
      .mrst_pulse(mrst_pulse), .axis_conv_en(axis_conv_en), .temp_conv_en(temp_conv_en),
      .st_field_x(st_field_x), .st_field_y(st_field_y));

   analog_front_model #(.CHARGE_CYC(8), .ST_FIELD(ST)) afe (.clk(clk), .slow_charge(slow),
      .cap_charge_en(cap_charge_en), .mrst_pulse(mrst_pulse), .conv_on(temp_conv_en),
      .st_field_x(st_field_x), .st_field_y(st_field_y), .amb({at, az, ay, ax}),
      .cap_charged_pin(cap_charged_pin), .adc_x(adc_x), .adc_y(adc_y), .adc_z(adc_z),
      .adc_t(adc_t));

   // Sampled on the rising edge so the falling-edge clears never race
   always @(posedge clk) begin
      n_mrst += (mrst_pulse === 1'b1);
      n_chg += (cap_charge_en === 1'b1);
      n_conv += (temp_conv_en === 1'b1);
      if (temp_conv_en === 1'b1) begin
         conv_axes = axis_conv_en;
         st_seen = st_seen | {st_field_y, st_field_x};
      end
   end

   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic send(input logic [7:0] code);
      @(negedge clk);
      cmd_wr = 1'b1;
      cmd_code = code;
      @(negedge clk);
      cmd_wr = 1'b0;
   endtask : send

   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(negedge clk);
      rd_en = 1'b1;
      rd_addr = a;
      @(negedge clk);
      q = rd_data;
      rd_en = 1'b0;
   endtask : rd

   task automatic clr();
      n_mrst = 0;
      n_chg = 0;
      n_conv = 0;
      st_seen = 2'h0;
   endtask : clr

   task automatic wait_idle(input bit norm);
      int w;
      w = 0;
      @(negedge clk);
      while (!((norm ? normal_state : suspend_state) === 1'b1 && conv_busy === 1'b0)
             && w < 3000) begin
         @(negedge clk);
         w++;
      end
      `CHK(w < 3000, 1'b1, "no return to idle")
   endtask : wait_idle

   task automatic forced(input logic [7:0] code, input int len, input bit dup);
      clr();
      send(code);
      if (dup) begin
         for (int w = 0; w < 400 && temp_conv_en !== 1'b1; w++) @(negedge clk);
         send(`FORCED_NORMAL_CMD);
      end
      wait_idle(1'b0);
      if (dup) repeat (300) @(negedge clk);
      `CHK(n_conv, len, "conversion length")
      `CHK(n_mrst, 200, "reset per tick")
      `CHK(drdy, 1'b1, "data ready")
      `CHK(suspend_state, 1'b1, "back in suspend")
   endtask : forced

   task automatic chk_data(input logic [95:0] f);
      for (int i = 0; i < 12; i++) begin
         rd(8'h31 + 8'(i), d);
         `CHK(d, f[8*i +: 8], "data byte")
      end
      rd(8'h40, d);
      `CHK(d, 8'h00, "unmapped read")
   endtask : chk_data

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      $display("[ERR] %0t watchdog expired", $time);
      final_report();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      {rst_n, cmd_wr, cmd_code, selftest_x_req, selftest_y_req, odr_tick} = '0;
      {rd_en, rd_addr, burst_active, drdy_clr, slow, avg_sel} = '0;
      axis_en = 3'h7;
      {ax, ay, az, at} = {24'h012345, 24'h0A0B0C, 24'h1F2E3D, 24'h004321};
      repeat (20) @(posedge clk);
      @(negedge clk);
      clr();
      rst_n = 1'b1;
      wait_idle(1'b0);
      `CHK(n_mrst, 200, "boot reset pulse")
      `CHK(n_chg <= CAPC + 1, 1'b1, "charge bound")
      `CHK({suspend_state, conv_busy}, 2'b10, "boot ends in suspend")
      $display("test boot done");
      for (int a = 0; a < 4; a++) begin
         avg_sel = 2'(a);
         ax = ax + 24'h000111;
         at = at ^ 24'h00F0F0;
         forced(`FORCED_NORMAL_CMD, NORM << a, 1'b0);
         chk_data({at, az, ay, ax});
         drdy_clr = 1'b1;
         @(negedge clk);
         drdy_clr = 1'b0;
         `CHK(drdy, 1'b0, "data ready clear")
      end
      $display("test averaging done");
      avg_sel = 2'h0;
      axis_en = 3'h5;
      forced(`FORCED_FAST_CMD, FAST, 1'b0);
      `CHK(conv_axes, 3'h5, "enabled axes")
      axis_en = 3'h7;
      avg_sel = 2'h1;
      forced(`FORCED_FAST_CMD, FAST << 1, 1'b1);
      $display("test fast and overlap done");
      foreach (bad[k]) begin
         send(bad[k]);
         repeat (3) @(negedge clk);
         `CHK({suspend_state, conv_busy}, 2'b10, "unknown code")
      end
      avg_sel = 2'h0;
      clr();
      send(`CMD_NORMAL);
      `CHK(normal_state, 1'b1, "normal entered")
      send(`FORCED_FAST_CMD);
      repeat (3) @(negedge clk);
      `CHK({normal_state, conv_busy}, 2'b10, "forced in normal")
      odr_tick = 1'b1;
      @(negedge clk);
      odr_tick = 1'b0;
      wait_idle(1'b1);
      `CHK(n_mrst, 200, "reset on rate tick")
      `CHK(n_conv, NORM, "normal conversion")
      send(`CMD_SUSPEND);
      `CHK(suspend_state, 1'b1, "suspend from normal")
      $display("test codes and normal done");
      slow = 1'b1;
      clr();
      send(`CMD_MAG_RESET);
      wait_idle(1'b0);
      `CHK(n_mrst, 200, "commanded reset")
      `CHK(n_chg, CAPC + 1, "charge timeout")
      `CHK(n_conv, 0, "no conversion")
      slow = 1'b0;
      foreach (st_req[k]) begin
         {selftest_y_req, selftest_x_req} = st_req[k];
         forced(`FORCED_FAST_CMD, FAST, 1'b0);
         `CHK(st_seen, st_exp[k], "one self-test axis")
         chk_data({at, az, ay + (st_exp[k][1] ? ST : 24'h0), ax + (st_exp[k][0] ? ST : 24'h0)});
      end
      {selftest_y_req, selftest_x_req} = 2'h0;
      $display("test reset and self-test done");
      // Burst must open with a data read in its first cycle to freeze
      @(negedge clk);
      burst_active = 1'b1;
      rd_en = 1'b1;
      rd_addr = 8'h31;
      @(negedge clk);
      old = rd_data;
      rd_en = 1'b0;
      ax = ax ^ 24'h0000FF;
      clr();
      send(`FORCED_FAST_CMD);
      for (int w = 0; w < 400 && !(n_conv == FAST && temp_conv_en === 1'b0); w++) @(negedge clk);
      repeat (5) @(negedge clk);
      rd(8'h31, d);
      `CHK(d, old, "frozen during burst")
      burst_active = 1'b0;
      wait_idle(1'b0);
      rd(8'h31, d);
      `CHK(d, ax[7:0], "written after burst")
      $display("test burst done");
      final_report();
   end
endmodule : forced_conversion_control_tb
